// ==== core/restart_wake_source_status.sv ====
// status bank recording restart, wake and failure sources, on APB
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps

module restart_wake_source_status #(
	parameter int unsigned MS_CYCLES    = restart_wake_pkg::MS_CYCLES,
	parameter int unsigned SAFE_WAIT_MS = restart_wake_pkg::SAFE_WAIT_MS,
	parameter int unsigned NORM_WAIT_MS = restart_wake_pkg::NORM_WAIT_MS
) (
	// clock and reset
	input  logic                          pclk,
	input  logic                          presetn,
	// apb slave
	input  logic                          psel,
	input  logic                          penable,
	input  logic                          pwrite,
	input  logic [7:0]                    paddr,
	input  logic [31:0]                   pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	// analog monitors, asynchronous levels
	input  restart_wake_pkg::monitor_in_s monitor_in,
	// event pulses from on-chip logic
	input  logic                          wd_fail,
	input  logic                          spi_invalid,
	input  logic                          sleep_req,
	// chip controls and status
	output logic                          reset_out_n,
	output logic                          fail_output,
	output logic                          fail_safe_mode,
	output logic                          module_off,
	output logic                          thermal_hold,
	output logic [3:0]                    status_info
);

	// ==================================================
	// monitor synchronisers
	logic [restart_wake_pkg::MON_W-1:0] mon_meta;
	logic [restart_wake_pkg::MON_W-1:0] mon_sync;
	logic [restart_wake_pkg::MON_W-1:0] mon_prev;
	restart_wake_pkg::monitor_in_s      mon;
	restart_wake_pkg::monitor_in_s      rise;

	genvar gi;
	generate
		for (gi = 0; gi < restart_wake_pkg::MON_W; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mon_meta[gi] <= 1'b0;
					mon_sync[gi] <= 1'b0;
					mon_prev[gi] <= 1'b0;
				end else begin
					mon_meta[gi] <= monitor_in[gi];
					mon_sync[gi] <= mon_meta[gi];
					mon_prev[gi] <= mon_sync[gi];
				end
			end
		end
	endgenerate

	assign mon  = restart_wake_pkg::monitor_in_s'(mon_sync);
	assign rise = restart_wake_pkg::monitor_in_s'(mon_sync & ~mon_prev);

	// ==================================================
	// millisecond tick
	localparam logic [restart_wake_pkg::MS_CNT_W-1:0] MS_LAST =
		restart_wake_pkg::MS_CNT_W'(MS_CYCLES - 1);
	logic [restart_wake_pkg::MS_CNT_W-1:0] ms_cnt_reg;
	logic                                  ms_tick_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_reg  <= '0;
			ms_tick_reg <= 1'b0;
		end else begin
			ms_tick_reg <= (ms_cnt_reg == MS_LAST);
			if (ms_cnt_reg == MS_LAST) begin
				ms_cnt_reg <= '0;
			end else begin
				ms_cnt_reg <= ms_cnt_reg + 1'b1;
			end
		end
	end

	// ==================================================
	// apb decode
	logic        pready_reg;
	logic        pslverr_reg;
	logic [31:0] prdata_reg;
	logic        access;
	logic        wr_en;
	logic        addr_hit;
	logic        wr_supply;
	logic        wr_wake;
	logic        wr_therm;
	logic        wr_device;
	logic        wr_ctrl;
	logic [7:0]  wdata;

	assign access    = psel & penable & ~pready_reg;
	// a write lands on the edge that completes the transfer
	assign wr_en     = psel & penable & pwrite & pready_reg;
	assign wdata     = pwdata[7:0];
	assign addr_hit  = (paddr == restart_wake_pkg::OFF_SUPPLY) |
	                   (paddr == restart_wake_pkg::OFF_WAKE) |
	                   (paddr == restart_wake_pkg::OFF_THERM) |
	                   (paddr == restart_wake_pkg::OFF_DEVICE) |
	                   (paddr == restart_wake_pkg::OFF_SUMMARY) |
	                   (paddr == restart_wake_pkg::OFF_CTRL);
	assign wr_supply = wr_en & (paddr == restart_wake_pkg::OFF_SUPPLY);
	assign wr_wake   = wr_en & (paddr == restart_wake_pkg::OFF_WAKE);
	assign wr_therm  = wr_en & (paddr == restart_wake_pkg::OFF_THERM);
	assign wr_device = wr_en & (paddr == restart_wake_pkg::OFF_DEVICE);
	assign wr_ctrl   = wr_en & (paddr == restart_wake_pkg::OFF_CTRL);

	// ==================================================
	// control register
	logic [7:0] ctrl_reg;
	logic [1:0] wd_cfg;
	logic [2:0] wake_en;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= restart_wake_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_reg <= wdata & restart_wake_pkg::CTRL_MASK;
		end
	end

	assign wd_cfg  = ctrl_reg[restart_wake_pkg::CTRL_CFG_LSB +: 2];
	assign wake_en = ctrl_reg[restart_wake_pkg::CTRL_WEN_LSB +: 3];

	// ==================================================
	// main rail short detection, counted in ms ticks
	localparam logic [restart_wake_pkg::SHORT_CNT_W-1:0] SHORT_MS =
		restart_wake_pkg::SHORT_CNT_W'(restart_wake_pkg::SHORT_TIME_MS);
	logic [restart_wake_pkg::SHORT_CNT_W-1:0] short_cnt_reg;
	logic                                     short_set;

	// third tick with the rail still low proves more than 2 ms
	assign short_set = mon.main_on & mon.main_uv & ms_tick_reg &
	                   (short_cnt_reg == SHORT_MS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			short_cnt_reg <= '0;
		end else if (!(mon.main_on & mon.main_uv)) begin
			short_cnt_reg <= '0;
		end else if (ms_tick_reg && short_cnt_reg <= SHORT_MS) begin
			short_cnt_reg <= short_cnt_reg + 1'b1;
		end
	end

	// ==================================================
	// high-level thermal shutdown sequencing
	localparam logic [restart_wake_pkg::TSD_CNT_W-1:0] SAFE_CNT =
		restart_wake_pkg::TSD_CNT_W'(restart_wake_pkg::SAFE_EVENT_COUNT);
	localparam logic [restart_wake_pkg::WAIT_W-1:0] WAIT_SAFE =
		restart_wake_pkg::WAIT_W'(SAFE_WAIT_MS);
	localparam logic [restart_wake_pkg::WAIT_W-1:0] WAIT_NORM =
		restart_wake_pkg::WAIT_W'(NORM_WAIT_MS);
	restart_wake_pkg::th_state_e             th_state_reg;
	logic [restart_wake_pkg::TSD_CNT_W-1:0]  tsd_cnt_reg;
	logic [restart_wake_pkg::WAIT_W-1:0]     wait_cnt_reg;
	logic [7:0]                              therm_reg;
	logic                                    safe_set;
	logic                                    tsd_cnt_clr;

	assign safe_set    = rise.therm_high & (tsd_cnt_reg == SAFE_CNT);
	assign tsd_cnt_clr = wr_therm & wdata[restart_wake_pkg::TH_HIGH];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tsd_cnt_reg <= '0;
		end else if (rise.therm_high) begin
			if (tsd_cnt_reg <= SAFE_CNT) begin
				tsd_cnt_reg <= tsd_cnt_reg + 1'b1;
			end
		end else if (tsd_cnt_clr) begin
			tsd_cnt_reg <= '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			th_state_reg <= restart_wake_pkg::TH_IDLE;
			wait_cnt_reg <= '0;
		end else begin
			unique case (th_state_reg)
				restart_wake_pkg::TH_IDLE: begin
					if (rise.therm_high) begin
						th_state_reg <= restart_wake_pkg::TH_SHUT;
					end
				end
				restart_wake_pkg::TH_SHUT: begin
					if (!mon.therm_high) begin
						th_state_reg <= restart_wake_pkg::TH_WAIT;
						wait_cnt_reg <= therm_reg[restart_wake_pkg::TH_SAFE] ?
						                WAIT_SAFE : WAIT_NORM;
					end
				end
				restart_wake_pkg::TH_WAIT: begin
					if (rise.therm_high) begin
						th_state_reg <= restart_wake_pkg::TH_SHUT;
					end else if (wait_cnt_reg == '0) begin
						th_state_reg <= restart_wake_pkg::TH_IDLE;
					end else if (ms_tick_reg) begin
						wait_cnt_reg <= wait_cnt_reg - 1'b1;
					end
				end
				default: begin
					th_state_reg <= restart_wake_pkg::TH_IDLE;
				end
			endcase
		end
	end

	// ==================================================
	// watchdog failure counter
	logic [1:0] wd_cnt_reg;
	logic [1:0] wd_limit;
	logic       wd_reach;

	assign wd_limit = (wd_cfg == restart_wake_pkg::CFG_2) ?
	                  restart_wake_pkg::WD_ONE : restart_wake_pkg::WD_TWO;
	assign wd_reach = wd_fail & (wd_cnt_reg == wd_limit - 2'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_cnt_reg <= restart_wake_pkg::WD_NONE;
		end else if (wd_fail && wd_cnt_reg < wd_limit) begin
			wd_cnt_reg <= wd_cnt_reg + 2'h1;
		end else if (wr_device && wdata[restart_wake_pkg::DEV_WD_LSB +: 2] != 2'h0) begin
			wd_cnt_reg <= restart_wake_pkg::WD_NONE;
		end
	end

	// ==================================================
	// fail-safe mode and prior state
	logic       any_wake;
	logic       fail_evt;
	logic [1:0] prior_reg;
	logic       fail_safe_reg;

	assign any_wake = rise.bus_wake | rise.timer_wake | rise.pin_wake;
	assign fail_evt = wd_fail | rise.therm_high | rise.main_uv |
	                  (sleep_req & (wake_en == 3'h0)) |
	                  (any_wake & fail_safe_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fail_safe_reg <= 1'b0;
		end else if (rise.therm_high) begin
			fail_safe_reg <= 1'b1;
		end else if (any_wake && th_state_reg == restart_wake_pkg::TH_IDLE) begin
			fail_safe_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prior_reg <= restart_wake_pkg::PRIOR_CLEAR;
		end else if (fail_evt) begin
			prior_reg <= restart_wake_pkg::PRIOR_FAIL;
		end else if (sleep_req) begin
			prior_reg <= restart_wake_pkg::PRIOR_SLEEP;
		end else if (wr_device && wdata[restart_wake_pkg::DEV_PRIOR_LSB +: 2] != 2'h0) begin
			prior_reg <= restart_wake_pkg::PRIOR_CLEAR;
		end
	end

	// ==================================================
	// sticky flags, set wins over a clear in the same cycle
	logic [7:0] supply_reg;
	logic [7:0] wake_reg;
	logic [1:0] dev_flag_reg;
	logic [7:0] supply_set;
	logic [7:0] wake_set;
	logic [7:0] therm_set;
	logic [1:0] dev_set;
	logic       fo_set;

	assign fo_set = wd_reach | rise.therm_high;

	always_comb begin
		supply_set = 8'h00;
		supply_set[restart_wake_pkg::SUP_SR_OT] = rise.second_ot;
		supply_set[restart_wake_pkg::SUP_SR_UV] = rise.second_uv;
		supply_set[restart_wake_pkg::SUP_SHORT] = short_set;
		supply_set[restart_wake_pkg::SUP_MR_UV] = rise.main_uv;
		wake_set = 8'h00;
		wake_set[restart_wake_pkg::WAKE_BUS]   = rise.bus_wake;
		wake_set[restart_wake_pkg::WAKE_TIMER] = rise.timer_wake;
		wake_set[restart_wake_pkg::WAKE_PIN]   = rise.pin_wake;
		therm_set = 8'h00;
		therm_set[restart_wake_pkg::TH_SAFE]    = safe_set;
		therm_set[restart_wake_pkg::TH_HIGH]    = rise.therm_high;
		therm_set[restart_wake_pkg::TH_LOW]     = rise.therm_low;
		therm_set[restart_wake_pkg::TH_PREWARN] = rise.prewarn;
		dev_set = {spi_invalid, fo_set};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_reg <= restart_wake_pkg::SUPPLY_RST;
		end else begin
			supply_reg <= ((supply_reg & ~({8{wr_supply}} & wdata)) |
			              supply_set) & restart_wake_pkg::SUPPLY_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_reg <= restart_wake_pkg::FLAGS_RST;
		end else begin
			wake_reg <= ((wake_reg & ~({8{wr_wake}} & wdata)) | wake_set) &
			            restart_wake_pkg::WAKE_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			therm_reg <= restart_wake_pkg::FLAGS_RST;
		end else begin
			therm_reg <= ((therm_reg & ~({8{wr_therm}} & wdata)) | therm_set) &
			             restart_wake_pkg::THERM_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_flag_reg <= 2'h0;
		end else begin
			dev_flag_reg <= (dev_flag_reg & ~({2{wr_device}} & wdata[1:0])) |
			                dev_set;
		end
	end

	// ==================================================
	// read view and chip outputs
	logic [7:0] device_view;
	logic [3:0] summary;
	logic [7:0] rd_sel;
	logic       reset_n_reg;
	logic       fail_out_reg;
	logic       module_off_reg;
	logic       hold_reg;
	logic [3:0] info_reg;

	assign device_view = {prior_reg, 2'b00, wd_cnt_reg, dev_flag_reg};
	assign summary = {|device_view, |therm_reg, |wake_reg, |supply_reg};

	always_comb begin
		unique case (paddr)
			restart_wake_pkg::OFF_SUPPLY:  rd_sel = supply_reg;
			restart_wake_pkg::OFF_WAKE:    rd_sel = wake_reg;
			restart_wake_pkg::OFF_THERM:   rd_sel = therm_reg;
			restart_wake_pkg::OFF_DEVICE:  rd_sel = device_view;
			restart_wake_pkg::OFF_SUMMARY: rd_sel = {4'h0, summary};
			restart_wake_pkg::OFF_CTRL:    rd_sel = ctrl_reg;
			default:                       rd_sel = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= access;
			pslverr_reg <= access & ~addr_hit;
			if (access && !pwrite) begin
				prdata_reg <= {24'h00_0000, rd_sel};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_n_reg    <= 1'b0;
			fail_out_reg   <= 1'b0;
			module_off_reg <= 1'b0;
			hold_reg       <= 1'b0;
			info_reg       <= 4'h0;
		end else begin
			reset_n_reg    <= ~mon.main_uv;
			module_off_reg <= mon.therm_low;
			hold_reg       <= (th_state_reg != restart_wake_pkg::TH_IDLE);
			info_reg       <= summary;
			if (fo_set) begin
				fail_out_reg <= 1'b1;
			end else if (wr_device && wdata[restart_wake_pkg::DEV_FO]) begin
				fail_out_reg <= 1'b0;
			end
		end
	end

	assign prdata         = prdata_reg;
	assign pready         = pready_reg;
	assign pslverr        = pslverr_reg;
	assign reset_out_n    = reset_n_reg;
	assign fail_output    = fail_out_reg;
	assign fail_safe_mode = fail_safe_reg;
	assign module_off     = module_off_reg;
	assign thermal_hold   = hold_reg;
	assign status_info    = info_reg;

	// ==================================================
	// checks
	sequence s_short_low;
		(mon.main_on & mon.main_uv) [*3];
	endsequence

	AST_POR_HELD: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(supply_reg[restart_wake_pkg::SUP_POR]) |->
		$past(wr_supply) && $past(wdata[restart_wake_pkg::SUP_POR]))
		else $error("power-on flag lost without a host clear");
	AST_WD_NEVER_THREE: assert property (@(posedge pclk) disable iff (!presetn)
		wd_cnt_reg != restart_wake_pkg::WD_NEVER)
		else $error("watchdog count reached three");
	AST_WD_FAIL_OUT: assert property (@(posedge pclk) disable iff (!presetn)
		wd_reach |=> wd_cnt_reg == $past(wd_limit) && fail_out_reg)
		else $error("watchdog limit did not raise fail output");
	AST_SAFE_AFTER_16: assert property (@(posedge pclk) disable iff (!presetn)
		rise.therm_high && tsd_cnt_reg == SAFE_CNT |=>
		therm_reg[restart_wake_pkg::TH_SAFE])
		else $error("safe state flag missing after 17th event");
	AST_SAFE_WAIT_60: assert property (@(posedge pclk) disable iff (!presetn)
		th_state_reg == restart_wake_pkg::TH_SHUT && !mon.therm_high &&
		therm_reg[restart_wake_pkg::TH_SAFE] |=> wait_cnt_reg == WAIT_SAFE)
		else $error("safe state wait not loaded");
	AST_HIGH_FAILSAFE: assert property (@(posedge pclk) disable iff (!presetn)
		rise.therm_high |=> fail_safe_reg && therm_reg[restart_wake_pkg::TH_HIGH]
		##1 fail_out_reg)
		else $error("high shutdown did not enter fail-safe");
	AST_LOW_MODULE: assert property (@(posedge pclk) disable iff (!presetn)
		rise.therm_low && !rise.therm_high && !fail_safe_reg |=>
		therm_reg[restart_wake_pkg::TH_LOW] && module_off_reg && !fail_safe_reg)
		else $error("low shutdown not flagged");
	AST_SHORT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		s_short_low ##0 (short_set) |=> supply_reg[restart_wake_pkg::SUP_SHORT])
		else $error("main rail short not flagged");
	AST_RESET_OUT: assert property (@(posedge pclk) disable iff (!presetn)
		mon.main_uv |=> !reset_out_n ##1 (reset_out_n || $past(mon.main_uv)))
		else $error("reset output not held during undervoltage");
	AST_PRIOR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!fail_evt && !sleep_req && !wr_device |=> $stable(prior_reg))
		else $error("prior state changed on its own");
	AST_SPI_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		spi_invalid |=> dev_flag_reg[restart_wake_pkg::DEV_SPI])
		else $error("serial fail flag not set");
	AST_SUMMARY: assert property (@(posedge pclk) disable iff (!presetn)
		(|wake_reg) |=> status_info[1] || !$past(|wake_reg))
		else $error("summary bit missing for wake register");

endmodule

// ==== core/restart_wake_pkg.sv ====
// constants, layouts and types for the restart and wake source status bank
package restart_wake_pkg;

	// ==================================================
	// register offsets (byte addresses on the register bus)
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  OFF_SUPPLY  = 8'h00;
	localparam logic [7:0]  OFF_WAKE    = 8'h04;
	localparam logic [7:0]  OFF_THERM   = 8'h08;
	localparam logic [7:0]  OFF_DEVICE  = 8'h0C;
	localparam logic [7:0]  OFF_SUMMARY = 8'h10;
	localparam logic [7:0]  OFF_CTRL    = 8'h14;

	// ==================================================
	// field positions
	localparam int unsigned SUP_POR       = 7;
	localparam int unsigned SUP_SR_OT     = 5;
	localparam int unsigned SUP_SR_UV     = 4;
	localparam int unsigned SUP_SHORT     = 3;
	localparam int unsigned SUP_MR_UV     = 1;
	localparam int unsigned WAKE_BUS      = 7;
	localparam int unsigned WAKE_TIMER    = 6;
	localparam int unsigned WAKE_PIN      = 4;
	localparam int unsigned TH_SAFE       = 7;
	localparam int unsigned TH_HIGH       = 6;
	localparam int unsigned TH_LOW        = 5;
	localparam int unsigned TH_PREWARN    = 4;
	localparam int unsigned DEV_PRIOR_LSB = 6;
	localparam int unsigned DEV_WD_LSB    = 2;
	localparam int unsigned DEV_SPI       = 1;
	localparam int unsigned DEV_FO        = 0;
	localparam int unsigned CTRL_CFG_LSB  = 0;
	localparam int unsigned CTRL_WEN_LSB  = 4;

	// ==================================================
	// implemented bits and reset values
	localparam logic [7:0] SUPPLY_MASK = 8'hBA;
	localparam logic [7:0] WAKE_MASK   = 8'hD0;
	localparam logic [7:0] THERM_MASK  = 8'hF0;
	localparam logic [7:0] CTRL_MASK   = 8'h73;
	localparam logic [7:0] SUPPLY_RST  = 8'h80;
	localparam logic [7:0] FLAGS_RST   = 8'h00;
	localparam logic [7:0] CTRL_RST    = 8'h00;

	// ==================================================
	// encodings
	localparam logic [1:0] CFG_1       = 2'h0;
	localparam logic [1:0] CFG_2       = 2'h1;
	localparam logic [1:0] PRIOR_CLEAR = 2'h0;
	localparam logic [1:0] PRIOR_FAIL  = 2'h1;
	localparam logic [1:0] PRIOR_SLEEP = 2'h2;
	localparam logic [1:0] WD_NONE     = 2'h0;
	localparam logic [1:0] WD_ONE      = 2'h1;
	localparam logic [1:0] WD_TWO      = 2'h2;
	localparam logic [1:0] WD_NEVER    = 2'h3;

	// ==================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned MS_NS            = 1000000;
	localparam int unsigned MS_CYCLES        = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned SHORT_TIME_MS    = 2;
	localparam int unsigned SAFE_WAIT_S      = 60;
	localparam int unsigned SAFE_WAIT_MS     = SAFE_WAIT_S * 1000;
	localparam int unsigned NORM_WAIT_MS     = 1000;
	localparam int unsigned SAFE_EVENT_COUNT = 16;
	localparam int unsigned MS_CNT_W         = 17;
	localparam int unsigned WAIT_W           = 16;
	localparam int unsigned TSD_CNT_W        = 5;
	localparam int unsigned SHORT_CNT_W      = 3;
	localparam int unsigned MON_W            = 10;

	// ==================================================
	// types
	typedef struct packed {
		logic bus_wake;
		logic timer_wake;
		logic pin_wake;
		logic therm_low;
		logic therm_high;
		logic prewarn;
		logic second_ot;
		logic second_uv;
		logic main_uv;
		logic main_on;
	} monitor_in_s;

	typedef enum logic [2:0] {
		TH_IDLE = 3'b001,
		TH_SHUT = 3'b010,
		TH_WAIT = 3'b100
	} th_state_e;

endpackage

// ==== verif/fault_source.sv ====
// model of the analog monitors that feed the status bank
`timescale 1ns/1ps
module fault_source (
	// clock
	input  wire logic                     pclk,
	// monitor levels
	output restart_wake_pkg::monitor_in_s monitor_in
);
	logic [9:0] lvl = 10'h000;
	assign monitor_in = lvl;
	task automatic set(input int idx, input logic v);
		@(posedge pclk);
		lvl[idx] <= v;
	endtask
	task automatic pulse(input int idx);
		set(idx, 1'b1);
		repeat (8) @(posedge pclk);
		lvl[idx] <= 1'b0;
	endtask
endmodule

// ==== verif/restart_wake_source_status_tb.sv ====
// self-checking bench for the restart and wake status bank
`timescale 1ns/1ps
module restart_wake_source_status_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, wd_fail = 1'b0, spi_invalid = 1'b0;
	logic sleep_req = 1'b0, pready, pslverr, reset_out_n, fail_output;
	logic fail_safe_mode, module_off, thermal_hold, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] status_info;
	restart_wake_pkg::monitor_in_s monitor_in;
	int bad_count = 0, n_tests = 0;
	always #5 pclk = ~pclk;
	fault_source i_src (.pclk(pclk), .monitor_in(monitor_in));
	restart_wake_source_status #(.MS_CYCLES(10), .SAFE_WAIT_MS(5),
		.NORM_WAIT_MS(2)) i_dut (.*);
	// ==========
	// shared tasks
	task automatic chk(input string n, input logic [31:0] e, g);
		n_tests++;
		if (e !== g) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("prdata", e, r);
	endtask
	task automatic pls(input int s);
		@(posedge pclk);
		case (s)
			0: spi_invalid <= 1'b1;
			1: wd_fail <= 1'b1;
			default: sleep_req <= 1'b1;
		endcase
		@(posedge pclk);
		spi_invalid <= 1'b0;
		wd_fail <= 1'b0;
		sleep_req <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_reset;
		rd(8'h00, 32'h80);
		rd(8'h18, 32'h0);
		chk("pslverr", 1, err);
		apb(1'b1, 8'h00, 32'hFF);
		rd(8'h00, 32'h0);
		rd(8'h08, 32'h0);
	endtask
	task automatic t_wake;
		for (int i = 0; i < 3; i++) begin
			i_src.pulse(9 - i);
			rd(8'h04, (i == 2) ? 32'h10 : 32'h80 >> i);
			chk("status_info", 4'h2, status_info);
			apb(1'b1, 8'h04, 32'hFF);
		end
		rd(8'h04, 32'h0);
	endtask
	task automatic t_dev;
		pls(0);
		rd(8'h0C, 32'h02);
		apb(1'b1, 8'h0C, 32'hFF);
		apb(1'b1, 8'h14, 32'h01);
		pls(1);
		pls(1);
		rd(8'h0C, 32'h45);
		chk("fail_output", 1, fail_output);
		apb(1'b1, 8'h0C, 32'hFF);
		rd(8'h0C, 32'h0);
		apb(1'b1, 8'h14, 32'h00);
		pls(1);
		chk("fail_output", 0, fail_output);
		pls(1);
		pls(1);
		rd(8'h0C, 32'h49);
		chk("fail_output", 1, fail_output);
		apb(1'b1, 8'h0C, 32'hFF);
		pls(2);
		rd(8'h0C, 32'h40);
		apb(1'b1, 8'h0C, 32'hC0);
		apb(1'b1, 8'h14, 32'h10);
		pls(2);
		rd(8'h0C, 32'h80);
		apb(1'b1, 8'h0C, 32'hFF);
	endtask
	task automatic t_uv;
		i_src.set(1, 1'b1);
		repeat (6) @(posedge pclk);
		chk("reset_out_n", 0, reset_out_n);
		i_src.set(1, 1'b0);
		repeat (6) @(posedge pclk);
		chk("reset_out_n", 1, reset_out_n);
		rd(8'h00, 32'h02);
		apb(1'b1, 8'h00, 32'hFF);
		apb(1'b1, 8'h0C, 32'hFF);
		i_src.pulse(3);
		i_src.pulse(2);
		rd(8'h00, 32'h30);
		i_src.set(0, 1'b1);
		i_src.set(1, 1'b1);
		repeat (60) @(posedge pclk);
		i_src.set(1, 1'b0);
		i_src.set(0, 1'b0);
		rd(8'h00, 32'h3A);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h80);
		rd(8'h0C, 32'h0);
		apb(1'b1, 8'h00, 32'hFF);
	endtask
	task automatic t_therm;
		int k;
		i_src.set(6, 1'b1);
		i_src.set(4, 1'b1);
		repeat (6) @(posedge pclk);
		chk("module_off", 1, module_off);
		rd(8'h08, 32'h30);
		apb(1'b1, 8'h08, 32'hFF);
		for (int i = 1; i <= 17; i++) begin
			i_src.pulse(5);
			for (k = 0; k < 300 && thermal_hold; k++) @(posedge pclk);
			if (i == 1) chk("fail_safe", 1, fail_safe_mode);
			if (i == 16) chk("short_wait", 1, k < 34);
			if (i == 16) rd(8'h08, 32'h40);
			if (i == 17) chk("long_wait", 1, k > 34);
		end
		rd(8'h08, 32'hC0);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_wake();
		t_dev();
		t_uv();
		t_therm();
		complete_run();
	end
	initial begin
		repeat (40000) @(posedge pclk);
		bad_count++;
		complete_run();
	end
endmodule
